// ==== inc/erx_pkg.sv ====
/*
 * Constants, opcodes and operation kinds for the extended read register
 * block: register layout, reset value, link opcodes, default dummy counts.
 * Assumes a single-line serial link run by an external host controller
 * and an operation engine that reports finished program and erase jobs.
 */
// Functional notes
// - fast read and 4-byte form: 8 dummies single-line, 6 four-line.
// - dual and quad output reads: 8 dummies, single-line mode only.
// - dual-I/O reads single and double rate: 4 dummies, single-line only.
// - quad-I/O reads 6 dummies both modes; double-rate single read 8/6.
// - 8-bit register: drive 7:5, pattern 4, erase 3, program 2, protect 1.
// - 85h writes non-volatile copy, 83h volatile; only bits 7:4 writable.
// - drive codes 1,2,3,5,6,7 give 12.5/25/37.5/75/100/50 percent.
// - protection flag set on program or erase into protected region.
// - program flag on program failure, protection block or NV write fail.
// - erase flag on erase failure, protection block or NV update fail.
// - page, protect-bit, password program fail set program; protect sets both.
// - info-row program fail sets program; locked region sets both flags.
// - protection-register program sets both if mode chosen or bits 00.
// - wrong unlock password sets program and protection flags.
// - NV update erase-part fail sets erase, program-part fail sets program.
// - locked status write sets protection and erase; unlocked, erase only on erase-part fail.
// - erases set erase on fail; protected or locked target sets both.
// - whole-array erase flags only block-protect hits, not sector bits.
// - OTP bits only go to 1; writing 0 is ignored, no flag.
// - read-only and frozen bits ignore written data, no flag.
// - error flags stay 1 until clear command or hardware/software reset.
// - commands keep executing normally while error flags are set.
package erx_pkg;

  // ******************************************************************
  // register layout
  // ******************************************************************
  localparam int unsigned EXT_REG_WIDTH = 8;
  localparam int unsigned DRIVE_MSB = 7;
  localparam int unsigned DRIVE_LSB = 5;
  localparam int unsigned LEARN_BIT = 4;
  localparam int unsigned ERASE_ERR_BIT = 3;
  localparam int unsigned PROG_ERR_BIT = 2;
  localparam int unsigned PROT_ERR_BIT = 1;
  localparam logic [7:0] EXT_REG_RESET = 8'hE0;
  localparam logic [7:0] EXT_WRITE_MASK = 8'hF0;

  // ******************************************************************
  // link opcodes
  // ******************************************************************
  localparam logic [7:0] OP_WRITE_EXT_NV = 8'h85;
  localparam logic [7:0] OP_WRITE_EXT_V = 8'h83;
  localparam logic [7:0] OP_READ_EXT = 8'h81;
  localparam logic [7:0] OP_CLEAR_EXT = 8'h82;
  localparam logic [7:0] OP_READ_UID = 8'h4B;
  localparam logic [7:0] OP_INFO_READ = 8'h68;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_FAST4 = 8'h0C;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_OUT4 = 8'h3C;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_QUAD_OUT4 = 8'h6C;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO4 = 8'hBC;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_QUAD_IO4 = 8'hEC;
  localparam logic [7:0] OP_SINGLE_DDR = 8'h0D;
  localparam logic [7:0] OP_SINGLE_DDR4 = 8'h0E;
  localparam logic [7:0] OP_DUAL_DDR = 8'hBD;
  localparam logic [7:0] OP_DUAL_DDR4 = 8'hBE;
  localparam logic [7:0] OP_QUAD_DDR = 8'hED;
  localparam logic [7:0] OP_QUAD_DDR4 = 8'hEE;

  // ******************************************************************
  // frame lengths and default dummy counts
  // ******************************************************************
  localparam logic [4:0] OPCODE_BITS = 5'h08;
  localparam logic [4:0] WRITE_FRAME_BITS = 5'h10;
  localparam logic [3:0] DUMMY_EIGHT = 4'h8;
  localparam logic [3:0] DUMMY_SIX = 4'h6;
  localparam logic [3:0] DUMMY_FOUR = 4'h4;

  // ******************************************************************
  // finished operations reported by the operation engine
  // ******************************************************************
  typedef enum logic [3:0] {
    KIND_PAGE_PROGRAM,
    KIND_PROTECT_BIT_PROGRAM,
    KIND_PASSWORD_PROGRAM,
    KIND_INFO_ROW_PROGRAM,
    KIND_PROT_REG_PROGRAM,
    KIND_PASSWORD_UNLOCK,
    KIND_NV_REG_UPDATE,
    KIND_STATUS_REG_WRITE,
    KIND_FUNCTION_REG_WRITE,
    KIND_SECTOR_ERASE,
    KIND_WHOLE_ARRAY_ERASE,
    KIND_INFO_ROW_ERASE,
    KIND_OTP_WRITE
  } erx_op_kind_type;

endpackage : erx_pkg

// ==== design/erx_dummy_lut.sv ====
/*
 * Default dummy-cycle lookup for the fast-read opcodes.
 * Assumes opcode and mode are stable in the cycle they are sampled.
 */
`timescale 1ns/1ps
module erx_dummy_lut
  import erx_pkg::*;
(
  input wire logic [7:0] opcode,
  input wire logic four_line_mode,
  output logic [3:0] dummy_count,
  output logic supported
);

  // ****************************************************************
  // opcode to default dummies
  // ****************************************************************
  always_comb begin
    dummy_count = 4'h0;
    supported = 1'b0;
    case (opcode)
      OP_FAST, OP_FAST4, OP_READ_UID, OP_INFO_READ,
      OP_SINGLE_DDR, OP_SINGLE_DDR4: begin
        supported = 1'b1;
        dummy_count = four_line_mode ? DUMMY_SIX : DUMMY_EIGHT;
      end
      OP_DUAL_OUT, OP_DUAL_OUT4, OP_QUAD_OUT, OP_QUAD_OUT4: begin
        supported = ~four_line_mode;
        dummy_count = DUMMY_EIGHT;
      end
      OP_DUAL_IO, OP_DUAL_IO4, OP_DUAL_DDR, OP_DUAL_DDR4: begin
        supported = ~four_line_mode;
        dummy_count = DUMMY_FOUR;
      end
      OP_QUAD_IO, OP_QUAD_IO4, OP_QUAD_DDR, OP_QUAD_DDR4: begin
        supported = 1'b1;
        dummy_count = DUMMY_SIX;
      end
      default: begin
        supported = 1'b0;
        dummy_count = 4'h0;
      end
    endcase
  end

endmodule : erx_dummy_lut

// ==== design/erx_core.sv ====
/*
 * Extended read register with sticky error flags, reached over a
 * single-line serial link (mode 0), plus default dummy-count reporting
 * for each read opcode seen on the link.
 * Assumes the link pins and the write-protect pin are asynchronous to
 * core_clk and much slower than it; the operation engine runs on
 * core_clk and pulses op_done once per finished job.
 */
`timescale 1ns/1ps
module erx_core
  import erx_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe,
  input wire logic write_protect_n,
  input wire logic four_line_mode,
  input wire logic soft_reset,
  input wire logic op_done,
  input wire erx_pkg::erx_op_kind_type op_kind,
  input wire logic op_fail,
  input wire logic op_erase_fail,
  input wire logic target_protected,
  input wire logic target_suspended,
  input wire logic info_row_locked,
  input wire logic prot_mode_chosen,
  input wire logic [1:0] prot_mode_bits,
  input wire logic password_mismatch,
  input wire logic status_write_disable_bit,
  input wire logic block_protect_hit,
  output logic [7:0] ext_reg_value,
  output logic [7:0] ext_reg_nv_value,
  output logic [2:0] drive_strength,
  output logic [3:0] drive_strength_eighths,
  output logic learning_pattern_enable,
  output logic [3:0] read_dummy_cycles,
  output logic read_cmd_supported
);
  import erx_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_d;
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic si_s1;
    logic si_s2;
    logic wp_s1;
    logic wp_s2;
    logic [4:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [7:0] tx;
    logic reading;
    logic so_out;
    logic so_oe;
    logic [7:0] nv_reg;
    logic [7:0] vol_reg;
    logic [3:0] eighths;
    logic [3:0] dummy;
    logic dummy_ok;
  } erx_state_type;

  localparam erx_state_type STATE_RESET = '{
    sck_s1: 1'b0, sck_s2: 1'b0, sck_d: 1'b0,
    cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
    si_s1: 1'b0, si_s2: 1'b0, wp_s1: 1'b1, wp_s2: 1'b1,
    bit_cnt: 5'h00, shift: 8'h00, opcode: 8'h00, tx: 8'h00,
    reading: 1'b0, so_out: 1'b0, so_oe: 1'b0,
    nv_reg: EXT_REG_RESET, vol_reg: EXT_REG_RESET,
    eighths: 4'h4, dummy: 4'h0, dummy_ok: 1'b0
  };

  erx_state_type st_ff;
  erx_state_type nxt_st;
  logic [7:0] cur_byte;
  logic [3:0] lut_dummy;
  logic lut_ok;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic set_prot;
  logic set_prog;
  logic set_erase;
  logic clear_flags;
  logic status_locked;

  // ****************************************************************
  // link edges and the byte being shifted in
  // ****************************************************************
  assign sck_rise = st_ff.sck_s2 & ~st_ff.sck_d;
  assign sck_fall = ~st_ff.sck_s2 & st_ff.sck_d;
  assign cs_rise = st_ff.cs_s2 & ~st_ff.cs_d;
  assign cur_byte = {st_ff.shift[6:0], st_ff.si_s2};
  assign status_locked = status_write_disable_bit & ~st_ff.wp_s2;

  // dummy counts for the opcode just completed
  erx_dummy_lut u_dummy_lut (
    .opcode(cur_byte),
    .four_line_mode(four_line_mode),
    .dummy_count(lut_dummy),
    .supported(lut_ok)
  );

  // ****************************************************************
  // error events from finished operations
  // ****************************************************************
  always_comb begin
    set_prot = 1'b0;
    set_prog = 1'b0;
    set_erase = 1'b0;
    if (op_done) begin
      case (op_kind)
        KIND_PAGE_PROGRAM, KIND_PROTECT_BIT_PROGRAM,
        KIND_PASSWORD_PROGRAM: begin
          set_prog = op_fail | target_protected | target_suspended;
          set_prot = target_protected | target_suspended;
        end
        KIND_INFO_ROW_PROGRAM: begin
          set_prog = op_fail | info_row_locked;
          set_prot = info_row_locked;
        end
        KIND_PROT_REG_PROGRAM: begin
          set_prog = op_fail | prot_mode_chosen
                     | (prot_mode_bits == 2'h0);
          set_prot = prot_mode_chosen | (prot_mode_bits == 2'h0);
        end
        KIND_PASSWORD_UNLOCK: begin
          set_prog = password_mismatch;
          set_prot = password_mismatch;
        end
        KIND_NV_REG_UPDATE: begin
          set_erase = op_erase_fail;
          set_prog = op_fail;
        end
        KIND_STATUS_REG_WRITE: begin
          set_erase = op_erase_fail | status_locked;
          set_prog = op_fail;
          set_prot = status_locked;
        end
        KIND_FUNCTION_REG_WRITE: begin
          set_prog = op_fail;
        end
        // array erase and info-row erase answer to different locks
        KIND_SECTOR_ERASE: begin
          set_erase = op_fail | target_protected;
          set_prot = target_protected;
        end
        KIND_INFO_ROW_ERASE: begin
          set_erase = op_fail | info_row_locked;
          set_prot = info_row_locked;
        end
        KIND_WHOLE_ARRAY_ERASE: begin
          set_erase = op_fail | block_protect_hit;
          set_prot = block_protect_hit;
        end
        KIND_OTP_WRITE: begin
          set_prog = 1'b0;
        end
        default: begin
          set_prog = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // next state: sync, link decode, register update, flags
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    clear_flags = soft_reset;
    nxt_st.sck_s1 = sck;
    nxt_st.sck_s2 = st_ff.sck_s1;
    nxt_st.sck_d = st_ff.sck_s2;
    nxt_st.cs_s1 = cs_n;
    nxt_st.cs_s2 = st_ff.cs_s1;
    nxt_st.cs_d = st_ff.cs_s2;
    nxt_st.si_s1 = si;
    nxt_st.si_s2 = st_ff.si_s1;
    nxt_st.wp_s1 = write_protect_n;
    nxt_st.wp_s2 = st_ff.wp_s1;
    // frame end: commit complete write or clear frames
    if (cs_rise) begin
      if (st_ff.bit_cnt == WRITE_FRAME_BITS) begin
        if (st_ff.opcode == OP_WRITE_EXT_V ||
            st_ff.opcode == OP_WRITE_EXT_NV) begin
          nxt_st.vol_reg = (st_ff.shift & EXT_WRITE_MASK)
                           | (st_ff.vol_reg & ~EXT_WRITE_MASK);
        end
        if (st_ff.opcode == OP_WRITE_EXT_NV) begin
          nxt_st.nv_reg = (st_ff.shift & EXT_WRITE_MASK)
                          | (st_ff.nv_reg & ~EXT_WRITE_MASK);
        end
      end
      if (st_ff.bit_cnt == OPCODE_BITS && st_ff.opcode == OP_CLEAR_EXT) begin
        clear_flags = 1'b1;
      end
    end
    if (st_ff.cs_s2) begin
      nxt_st.bit_cnt = 5'h00;
      nxt_st.reading = 1'b0;
      nxt_st.so_oe = 1'b0;
    end else if (sck_rise) begin
      nxt_st.shift = cur_byte;
      if (st_ff.bit_cnt != 5'h1F) begin
        nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
      end
      if (st_ff.bit_cnt == OPCODE_BITS - 5'h01) begin
        nxt_st.opcode = cur_byte;
        nxt_st.dummy = lut_dummy;
        nxt_st.dummy_ok = lut_ok;
        if (cur_byte == OP_READ_EXT) begin
          nxt_st.reading = 1'b1;
          nxt_st.tx = st_ff.vol_reg;
        end
      end
    end else if (sck_fall && st_ff.reading) begin
      // register repeats msb first while the frame lasts
      nxt_st.so_oe = 1'b1;
      nxt_st.so_out = st_ff.tx[7];
      nxt_st.tx = {st_ff.tx[6:0], st_ff.tx[7]};
    end
    // software reset reloads the writable bits from the nv copy
    if (soft_reset) begin
      nxt_st.vol_reg[DRIVE_MSB:LEARN_BIT] = st_ff.nv_reg[DRIVE_MSB:LEARN_BIT];
    end
    // sticky flags: clear first, then new events win
    if (clear_flags) begin
      nxt_st.vol_reg[ERASE_ERR_BIT] = 1'b0;
      nxt_st.vol_reg[PROG_ERR_BIT] = 1'b0;
      nxt_st.vol_reg[PROT_ERR_BIT] = 1'b0;
    end
    nxt_st.vol_reg[ERASE_ERR_BIT] = nxt_st.vol_reg[ERASE_ERR_BIT]
                                     | set_erase;
    nxt_st.vol_reg[PROG_ERR_BIT] = nxt_st.vol_reg[PROG_ERR_BIT]
                                    | set_prog;
    nxt_st.vol_reg[PROT_ERR_BIT] = nxt_st.vol_reg[PROT_ERR_BIT]
                                    | set_prot;
    nxt_st.vol_reg[0] = 1'b0;
    // drive code to strength in eighths of full
    case (nxt_st.vol_reg[DRIVE_MSB:DRIVE_LSB])
      3'h1: nxt_st.eighths = 4'h1;
      3'h2: nxt_st.eighths = 4'h2;
      3'h3: nxt_st.eighths = 4'h3;
      3'h5: nxt_st.eighths = 4'h6;
      3'h6: nxt_st.eighths = 4'h8;
      3'h7: nxt_st.eighths = 4'h4;
      default: nxt_st.eighths = 4'h0;
    endcase
  end

  // ****************************************************************
  // state register; flags never stall the link decoder
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs, all from flops
  // ****************************************************************
  assign so_out = st_ff.so_out;
  assign so_oe = st_ff.so_oe;
  assign ext_reg_value = st_ff.vol_reg;
  assign ext_reg_nv_value = st_ff.nv_reg;
  assign drive_strength = st_ff.vol_reg[DRIVE_MSB:DRIVE_LSB];
  assign drive_strength_eighths = st_ff.eighths;
  assign learning_pattern_enable = st_ff.vol_reg[LEARN_BIT];
  assign read_dummy_cycles = st_ff.dummy;
  assign read_cmd_supported = st_ff.dummy_ok;

endmodule : erx_core

// ==== tb/erx_core_properties.sv ====
/* checker for erx_core: sticky flags, drive decode, four-line dummy counts.
   assumes a bind onto erx_core and a link much slower than core_clk. */
`timescale 1ns/1ps
module erx_core_properties (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic so_oe,
  input wire logic write_protect_n,
  input wire logic four_line_mode,
  input wire logic soft_reset,
  input wire logic op_done,
  input wire erx_pkg::erx_op_kind_type op_kind,
  input wire logic target_protected,
  input wire logic prot_mode_chosen,
  input wire logic [1:0] prot_mode_bits,
  input wire logic password_mismatch,
  input wire logic status_write_disable_bit,
  input wire logic block_protect_hit,
  input wire logic [7:0] ext_reg_value,
  input wire logic [2:0] drive_strength,
  input wire logic [3:0] drive_strength_eighths,
  input wire logic [3:0] read_dummy_cycles,
  input wire logic read_cmd_supported
);
  import erx_pkg::*;
  // eighths per drive code, a nibble each, code 7 on top
  localparam logic [31:0] EIGHTHS_LUT = 32'h48603210;
  logic [3:0] cs_hi_ff;
  wire op_ok = op_done && !soft_reset;
  wire quiet = cs_hi_ff > 4'h6;
  // ****************************************
  // select-high count: past 6, no frame commit is pending
  // ****************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      cs_hi_ff <= 4'h0;
    else if (!cs_n)
      cs_hi_ff <= 4'h0;
    else if (cs_hi_ff != 4'hF)
      cs_hi_ff <= cs_hi_ff + 4'h1;
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  property p_prog_prot;
    op_ok && op_kind == KIND_PAGE_PROGRAM && target_protected
      |=> ext_reg_value[2:1] == 2'h3;
  endproperty
  a_prog_prot: assert property (p_prog_prot)
    else $error("protected program left flags clear");
  property p_unlock;
    op_ok && op_kind == KIND_PASSWORD_UNLOCK && password_mismatch
      |=> ext_reg_value[2:1] == 2'h3;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("bad unlock left flags clear");
  property p_prot_reg;
    op_ok && op_kind == KIND_PROT_REG_PROGRAM
      && (prot_mode_chosen || prot_mode_bits == 2'h0)
      |=> ext_reg_value[2:1] == 2'h3;
  endproperty
  a_prot_reg: assert property (p_prot_reg)
    else $error("bad mode program left flags clear");
  property p_status_lock;
    op_ok && op_kind == KIND_STATUS_REG_WRITE && status_write_disable_bit
      && !write_protect_n && $past(write_protect_n, 2) == 1'b0
      |=> ext_reg_value[3] && ext_reg_value[1];
  endproperty
  a_status_lock: assert property (p_status_lock)
    else $error("locked status write left flags clear");
  property p_chip;
    op_ok && op_kind == KIND_WHOLE_ARRAY_ERASE && block_protect_hit
      |=> ext_reg_value[3] && ext_reg_value[1];
  endproperty
  a_chip: assert property (p_chip)
    else $error("covered whole erase left flags clear");
  property p_otp;
    op_ok && quiet && op_kind == KIND_OTP_WRITE
      |=> $stable(ext_reg_value[3:1]);
  endproperty
  a_otp: assert property (p_otp)
    else $error("otp write moved a flag");
  property p_sticky;
    quiet && !$past(soft_reset) |-> !$fell(ext_reg_value[1])
      && !$fell(ext_reg_value[2]) && !$fell(ext_reg_value[3]);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without a clear");
  property p_reserved;
    ext_reg_value[0] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit set");
  property p_eighths;
    drive_strength_eighths == EIGHTHS_LUT[{drive_strength, 2'b00} +: 4];
  endproperty
  a_eighths: assert property (p_eighths)
    else $error("drive decode wrong");
  property p_four_line;
    $changed(read_dummy_cycles) && read_cmd_supported && four_line_mode
      |-> read_dummy_cycles == 4'h6;
  endproperty
  a_four_line: assert property (p_four_line)
    else $error("four-line dummy count wrong");
  c_read: cover property ($rose(so_oe));
  c_chip: cover property (op_ok && op_kind == KIND_WHOLE_ARRAY_ERASE);
  c_clear: cover property ($fell(ext_reg_value[2]));
endmodule : erx_core_properties
bind erx_core erx_core_properties u_props (.core_clk, .reset_n, .cs_n,
  .so_oe, .write_protect_n, .four_line_mode, .soft_reset, .op_done,
  .op_kind, .target_protected, .prot_mode_chosen, .prot_mode_bits,
  .password_mismatch, .status_write_disable_bit, .block_protect_hit,
  .ext_reg_value, .drive_strength, .drive_strength_eighths,
  .read_dummy_cycles, .read_cmd_supported);

// ==== tb/erx_host_model.sv ====
/* host link controller: mode 0 frames, msb first, sck idle low.
   assumes core_clk paces it; sck half period is 4 core cycles. */
`timescale 1ns/1ps
module erx_host_model (
  input wire logic core_clk,
  input wire logic so_out,
  input wire logic so_oe,
  output logic sck,
  output logic cs_n,
  output logic si
);
  // host never drives the data-out line; released it reads inverted
  wire so_line = so_oe ? so_out : ~so_out;
  // idle link at time zero
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // one frame of n bits; data out captured just before each fall
  task automatic xfer(input logic [15:0] bits, input int n,
                      output logic [7:0] rd);
    rd = 8'h00;
    @(posedge core_clk);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      si <= bits[15-i];
      repeat (4) @(posedge core_clk);
      sck <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd = {rd[6:0], so_line};
      sck <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge core_clk);
  endtask : xfer
endmodule : erx_host_model

// ==== tb/ext_read_reg_error_status_tb.sv ====
/* bench for erx_core: register frames, dummy counts, error flags.
   assumes erx_host_model on the link and the erx_pkg constants. */
`timescale 1ns/1ps
module ext_read_reg_error_status_tb;
  import erx_pkg::*;
  localparam logic [31:0] EIGHTHS_LUT = 32'h48603210;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic four_line_mode = 1'b0;
  logic soft_reset = 1'b0;
  logic op_done = 1'b0;
  erx_op_kind_type op_kind = KIND_PAGE_PROGRAM;
  logic [11:0] q = 12'h200;
  logic sck, cs_n, si, so_out, so_oe, learning_pattern_enable;
  logic read_cmd_supported;
  logic [2:0] drive_strength;
  logic [3:0] drive_strength_eighths, read_dummy_cycles;
  logic [7:0] ext_reg_value, ext_reg_nv_value, m_reg, m_nv, rd;
  logic [7:0] ops [18] = '{8'h0B, 8'h0C, 8'h4B, 8'h68, 8'h3B, 8'h3C,
    8'h6B, 8'h6C, 8'hBB, 8'hBC, 8'hEB, 8'hEC, 8'h0D, 8'h0E, 8'hBD,
    8'hBE, 8'hED, 8'hEE};
  int err_count = 0;
  int comparisons = 0;
  // 10 MHz core clock
  always #50 core_clk = ~core_clk;
  erx_core uut (.core_clk, .reset_n, .sck, .cs_n, .si, .so_out, .so_oe,
    .write_protect_n(q[9]), .four_line_mode, .soft_reset, .op_done,
    .op_kind, .op_fail(q[0]), .op_erase_fail(q[1]),
    .target_protected(q[2]), .target_suspended(q[3]),
    .info_row_locked(q[4]), .prot_mode_chosen(q[5]),
    .prot_mode_bits(q[11:10]), .password_mismatch(q[6]),
    .status_write_disable_bit(q[7]), .block_protect_hit(q[8]),
    .ext_reg_value, .ext_reg_nv_value, .drive_strength,
    .drive_strength_eighths, .learning_pattern_enable,
    .read_dummy_cycles, .read_cmd_supported);
  erx_host_model host (.core_clk, .so_out, .so_oe, .sck, .cs_n, .si);
  // flags {erase, program, protect} a finished job must raise
  function automatic logic [2:0] exp_flags(input erx_op_kind_type k,
                                            input logic [11:0] v);
    logic bad;
    logic lock;
    bad = v[5] | (v[11:10] == 2'b00);
    lock = v[7] & ~v[9];
    case (k)
      KIND_PAGE_PROGRAM, KIND_PROTECT_BIT_PROGRAM, KIND_PASSWORD_PROGRAM:
        return {1'b0, v[0] | v[2] | v[3], v[2] | v[3]};
      KIND_INFO_ROW_PROGRAM: return {1'b0, v[0] | v[4], v[4]};
      KIND_PROT_REG_PROGRAM: return {1'b0, v[0] | bad, bad};
      KIND_PASSWORD_UNLOCK: return {1'b0, v[6], v[6]};
      KIND_NV_REG_UPDATE: return {v[1], v[0], 1'b0};
      KIND_STATUS_REG_WRITE: return {v[1] | lock, v[0], lock};
      KIND_FUNCTION_REG_WRITE: return {1'b0, v[0], 1'b0};
      KIND_SECTOR_ERASE: return {v[0] | v[2], 1'b0, v[2]};
      KIND_WHOLE_ARRAY_ERASE: return {v[0] | v[8], 1'b0, v[8]};
      KIND_INFO_ROW_ERASE: return {v[0] | v[4], 1'b0, v[4]};
      default: return 3'h0;
    endcase
  endfunction : exp_flags
  // {supported, dummy count} for an opcode in a command mode
  function automatic logic [4:0] exp_dummy(input logic [7:0] o,
                                           input logic m);
    case (o)
      8'h0B, 8'h0C, 8'h4B, 8'h68, 8'h0D, 8'h0E:
        return m ? 5'h16 : 5'h18;
      8'h3B, 8'h3C, 8'h6B, 8'h6C: return m ? 5'h00 : 5'h18;
      8'hBB, 8'hBC, 8'hBD, 8'hBE: return m ? 5'h00 : 5'h14;
      8'hEB, 8'hEC, 8'hED, 8'hEE: return 5'h16;
      default: return 5'h00;
    endcase
  endfunction : exp_dummy
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic link(input logic [15:0] b, input int n);
    host.xfer(b, n, rd);
    #1;
  endtask : link
  // one finished job, then the flags one cycle after the pulse
  task automatic run_op(input erx_op_kind_type k, input logic [11:0] v);
    @(posedge core_clk);
    op_kind <= k;
    q <= v;
    repeat (4) @(posedge core_clk);
    op_done <= 1'b1;
    @(posedge core_clk);
    op_done <= 1'b0;
    @(posedge core_clk);
    #1;
    m_reg[3:1] = m_reg[3:1] | exp_flags(k, v);
    chk("flags", m_reg, ext_reg_value);
  endtask : run_op
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    int c;
    logic [7:0] d;
    logic [11:0] v;
    logic [4:0] ed;
    erx_op_kind_type k;
    c = $urandom(32'h5C472E5D);
    m_reg = 8'hE0;
    m_nv = 8'hE0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk("reset value", m_reg, ext_reg_value);
    chk("nv reset", m_nv, ext_reg_nv_value);
    chk("eighths", 8'h04, {4'h0, drive_strength_eighths});
    $display("test reset done");
    run_op(KIND_PASSWORD_UNLOCK, 12'h240);
    for (c = 0; c < 8; c++) begin
      d = {c[2:0], 5'($urandom)};
      link({c[0] ? 8'h85 : 8'h83, d}, 16);
      m_reg[7:4] = d[7:4];
      if (c[0])
        m_nv[7:4] = d[7:4];
      chk("register", m_reg, ext_reg_value);
      chk("nv copy", m_nv[7:4], ext_reg_nv_value[7:4]);
      chk("eighths", EIGHTHS_LUT[{d[7:5], 2'b00} +: 4],
          {4'h0, drive_strength_eighths});
      chk("learn bit", d[4], learning_pattern_enable);
      chk("drive", d[7:5], drive_strength);
    end
    $display("test writes done");
    link({8'h83, ~m_reg}, 15);
    chk("short write", m_reg, ext_reg_value);
    link(16'h8100, 16);
    chk("read back", m_reg, rd);
    $display("test read done");
    for (c = 0; c < 36; c++) begin
      four_line_mode <= c[0];
      link({ops[c/2], 8'h00}, 8);
      ed = exp_dummy(ops[c/2], c[0]);
      chk("supported", ed[4], read_cmd_supported);
      if (ed[4])
        chk("dummy", ed[3:0], read_dummy_cycles);
    end
    four_line_mode <= 1'b0;
    $display("test dummy done");
    for (c = 0; c < 60; c++) begin
      k = erx_op_kind_type'((c < 13) ? c : $urandom_range(12));
      v = 12'($urandom);
      if (k == KIND_PASSWORD_UNLOCK)
        v[0] = 1'b0;
      run_op(k, v);
      if (c % 3 == 2) begin
        link(16'h8200, 8);
        m_reg[3:1] = 3'h0;
        chk("cleared", m_reg, ext_reg_value);
      end
    end
    $display("test events done");
    @(posedge core_clk);
    q <= 12'h201;
    op_done <= 1'b1;
    op_kind <= KIND_PAGE_PROGRAM;
    @(posedge core_clk);
    op_kind <= KIND_SECTOR_ERASE;
    @(posedge core_clk);
    op_done <= 1'b0;
    @(posedge core_clk);
    #1;
    m_reg = m_reg | 8'h0C;
    chk("back to back", m_reg, ext_reg_value);
    $display("test back_to_back done");
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    m_reg = {m_nv[7:4], 4'h0};
    chk("soft reset", m_reg, ext_reg_value);
    $display("test soft_reset done");
    give_verdict();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    err_count++;
    give_verdict();
  end
endmodule : ext_read_reg_error_status_tb
